//--- drive_geometry_block_loader.v
// Purpose: fetches parameter blocks from host memory and stores drive geometry
// Assumes: a word-read DMA port into host memory, classic Wishbone for registers
// Notes:   nonvolatile store is a write port of flip-flop images handed outward
//
// Register access over Wishbone and the address map are this design's own decisions.
`include "geometry_loader_consts.vh"

// Summary of operation
// R1: block is sixteen 16-bit words
// R2: host keeps blocks contiguous below 64K
// R3: first block drive 0, next drive 1
// R4: words are unsigned, right-justified, bit 15 top
// R5: unit count at most two; zero ignored
// R6: media type must be one
// R7: split 3 maps heads by offset
// R8: sectors per track within 1 to 63
// R9: heads per drive within 1 to 16
// R10: cylinders within 1 to 4095
// R11: spare sectors 0 or 1, added
// R12: alternates 0 to 127, added to cylinders
// R13: spare sectors need two alternates
// R14: alternates halved for split 1, 2
// R15: reserved ninth word is zero
// R16: split 0 whole, split 1 halves
// R17: split 2 seven eighths plus remainder
// R18: split 3 partitions data heads
// R19: any split disables seek reordering
// R20: split gives two logical units
// R21: stop when next unit count is zero
// R22: reject bad block, store unchanged
module drive_geometry_block_loader (
    // clock and reset
    input  wire        i_core_clk,
    input  wire        i_reset,
    // wishbone slave
    input  wire        i_wb_cyc,
    input  wire        i_wb_stb,
    input  wire        i_wb_we,
    input  wire [3:0]  i_wb_adr,
    input  wire [3:0]  i_wb_sel,
    input  wire [31:0] i_wb_dat,
    output reg  [31:0] o_wb_dat,
    output reg         o_wb_ack,
    // host memory read port
    output reg         o_dma_req,
    output reg  [15:0] o_dma_addr,
    input  wire        i_dma_ack,
    input  wire [15:0] i_dma_data,
    // nonvolatile geometry store write port
    output reg         o_store_we,
    output reg         o_store_drive,
    output reg  [5:0]  o_store_phys_sectors,
    output reg  [12:0] o_store_phys_cyls,
    output reg  [4:0]  o_store_heads,
    output reg  [1:0]  o_store_split,
    output reg  [4:0]  o_store_head_ofs,
    output reg  [11:0] o_store_ld0_cyls,
    output reg  [11:0] o_store_ld1_cyls,
    output reg  [6:0]  o_store_ld0_alts,
    output reg  [6:0]  o_store_ld1_alts,
    output reg  [4:0]  o_store_ld0_heads,
    output reg  [4:0]  o_store_ld1_heads,
    output reg         o_store_two_units,
    // drive mapping control
    output reg         o_seek_reorder_en
);
    // loader states
    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_FETCH = 3'h1;
    localparam [2:0] S_CHECK = 3'h2;
    localparam [2:0] S_STORE = 3'h3;
    localparam [2:0] S_DONE  = 3'h4;

    reg  [2:0]  state_q;            // loader state
    reg  [15:0] addr_q;             // next host word address
    reg  [4:0]  word_idx_q;         // index inside current block
    reg  [15:0] words_q [0:9];      // words 1 to 10 of the block
    reg         drive_q;            // physical drive of current block
    reg         err_q;              // sticky reject flag
    reg         done_q;             // sticky completion flag
    reg         split_any_q;        // some stored drive is split
    reg  [15:0] start_addr_q;       // first word address from software
    reg  [11:0] ld0_cyls_q;         // logical drive 0 size of the last stored block
    reg         store_second_q;     // second store write pending (two units)

    // checker outputs
    wire        blk_valid;
    wire [5:0]  phys_sectors;
    wire [12:0] phys_cyls;
    wire [11:0] ld0_cyls;
    wire [11:0] ld1_cyls;
    wire [6:0]  ld0_alts;
    wire [6:0]  ld1_alts;
    wire [4:0]  ld0_heads;
    wire [4:0]  ld1_heads;
    wire        split_on;

    wire        busy      = (state_q != S_IDLE) && (state_q != S_DONE);
    wire        wb_access = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire        go_write  = wb_access && i_wb_we && (i_wb_adr == `REG_CTRL)
                            && i_wb_sel[0] && i_wb_dat[`CTRL_GO_BIT];

    // field checker and layout derivation
    geometry_block_check u_check (
        .i_units        (words_q[`W_UNITS]),
        .i_type         (words_q[`W_TYPE]),
        .i_head_ofs     (words_q[`W_HEAD_OFS]),
        .i_sectors      (words_q[`W_SECTORS]),
        .i_heads        (words_q[`W_HEADS]),
        .i_cyls         (words_q[`W_CYLS]),
        .i_spare_sec    (words_q[`W_SPARE_SEC]),
        .i_alt_cyls     (words_q[`W_ALT_CYLS]),
        .i_reserved     (words_q[`W_RESERVED]),
        .i_split        (words_q[`W_SPLIT]),
        .o_valid        (blk_valid),
        .o_phys_sectors (phys_sectors),
        .o_phys_cyls    (phys_cyls),
        .o_ld0_cyls     (ld0_cyls),
        .o_ld1_cyls     (ld1_cyls),
        .o_ld0_alts     (ld0_alts),
        .o_ld1_alts     (ld1_alts),
        .o_ld0_heads    (ld0_heads),
        .o_ld1_heads    (ld1_heads),
        .o_split_on     (split_on)
    );

    // wishbone slave: ack registered one cycle after the request, unmapped reads return zero
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_wb_ack     <= 1'b0;
            o_wb_dat     <= 32'h0000_0000;
            start_addr_q <= 16'h0000;
        end else begin
            o_wb_ack <= wb_access;
            if (wb_access && i_wb_we && (i_wb_adr == `REG_START_ADDR) && !busy) begin
                // word address, kept in the low 64K  R2
                if (i_wb_sel[0]) begin
                    start_addr_q[7:0] <= i_wb_dat[7:0];
                end
                if (i_wb_sel[1]) begin
                    start_addr_q[15:8] <= i_wb_dat[15:8];
                end
            end
            if (wb_access && !i_wb_we) begin
                case (i_wb_adr)
                    `REG_START_ADDR: begin
                        o_wb_dat <= {16'h0000, start_addr_q};
                    end
                    `REG_STATUS: begin
                        o_wb_dat <= {28'h0000000, !split_any_q, err_q, done_q, busy};
                    end
                    `REG_LD0_CYLS: begin
                        o_wb_dat <= {20'h00000, ld0_cyls_q};
                    end
                    default: begin
                        o_wb_dat <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // block fetch, check and store sequence
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            state_q           <= S_IDLE;
            addr_q            <= 16'h0000;
            word_idx_q        <= 5'h00;
            drive_q           <= 1'b0;
            err_q             <= 1'b0;
            done_q            <= 1'b0;
            split_any_q       <= 1'b0;
            ld0_cyls_q        <= 12'h000;
            store_second_q    <= 1'b0;
            o_dma_req         <= 1'b0;
            o_dma_addr        <= 16'h0000;
            o_store_we        <= 1'b0;
            o_store_drive     <= 1'b0;
            o_store_phys_sectors <= 6'h00;
            o_store_phys_cyls <= 13'h0000;
            o_store_heads     <= 5'h00;
            o_store_split     <= 2'h0;
            o_store_head_ofs  <= 5'h00;
            o_store_ld0_cyls  <= 12'h000;
            o_store_ld1_cyls  <= 12'h000;
            o_store_ld0_alts  <= 7'h00;
            o_store_ld1_alts  <= 7'h00;
            o_store_ld0_heads <= 5'h00;
            o_store_ld1_heads <= 5'h00;
            o_store_two_units <= 1'b0;
            o_seek_reorder_en <= 1'b1;
        end else begin
            o_store_we <= 1'b0;
            case (state_q)
                S_IDLE, S_DONE: begin
                    if (go_write) begin
                        state_q     <= S_FETCH;
                        addr_q      <= start_addr_q;
                        o_dma_addr  <= start_addr_q;
                        o_dma_req   <= 1'b1;
                        word_idx_q  <= 5'h00;
                        drive_q     <= 1'b0;          // lowest block is drive 0  R3
                        err_q       <= 1'b0;
                        done_q      <= 1'b0;
                        split_any_q <= 1'b0;
                    end
                end
                S_FETCH: begin
                    if (i_dma_ack) begin
                        if (word_idx_q < 5'd10) begin
                            words_q[word_idx_q[3:0]] <= i_dma_data;   // R4
                        end
                        if (word_idx_q == 5'h00 && i_dma_data == 16'h0000) begin
                            // zero unit count ends the list  R21 R5
                            o_dma_req <= 1'b0;
                            done_q    <= 1'b1;
                            state_q   <= S_DONE;
                        end else if (word_idx_q == `BLK_WORDS - 5'd1) begin
                            // whole sixteen-word block read  R1
                            o_dma_req <= 1'b0;
                            state_q   <= S_CHECK;
                        end else begin
                            o_dma_addr <= addr_q + 16'h0001;  // contiguous upward  R2
                        end
                        addr_q     <= addr_q + 16'h0001;
                        word_idx_q <= word_idx_q + 5'd1;
                    end
                end
                S_CHECK: begin
                    if (!blk_valid || (drive_q && words_q[`W_UNITS] == `MAX_UNITS)) begin
                        // out-of-range block: store left untouched  R22
                        err_q   <= 1'b1;
                        state_q <= S_DONE;
                    end else begin
                        o_store_we           <= 1'b1;
                        o_store_drive        <= drive_q;             // R3
                        o_store_phys_sectors <= phys_sectors;        // R11
                        o_store_phys_cyls    <= phys_cyls;           // R12
                        o_store_heads        <= words_q[`W_HEADS][4:0];
                        o_store_split        <= words_q[`W_SPLIT][1:0];
                        // offset kept only for head split  R7
                        o_store_head_ofs     <= (words_q[`W_SPLIT][1:0] == `SPLIT_HEADS)
                                                ? words_q[`W_HEAD_OFS][4:0] : 5'h00;
                        o_store_ld0_cyls     <= ld0_cyls;            // R16 R17
                        o_store_ld1_cyls     <= ld1_cyls;
                        o_store_ld0_alts     <= ld0_alts;            // R14
                        o_store_ld1_alts     <= ld1_alts;
                        o_store_ld0_heads    <= ld0_heads;           // R18
                        o_store_ld1_heads    <= ld1_heads;
                        o_store_two_units    <= split_on;            // R20
                        ld0_cyls_q           <= ld0_cyls;
                        if (split_on) begin
                            split_any_q       <= 1'b1;
                            o_seek_reorder_en <= 1'b0;               // R19
                        end
                        // a count of two covers drive 1 as well  R3
                        store_second_q <= (words_q[`W_UNITS] == `MAX_UNITS);
                        state_q        <= S_STORE;
                    end
                end
                S_STORE: begin
                    if (store_second_q) begin
                        o_store_we     <= 1'b1;
                        o_store_drive  <= 1'b1;                      // R3
                        store_second_q <= 1'b0;
                        drive_q        <= 1'b1;
                        done_q         <= 1'b1;
                        state_q        <= S_DONE;
                    end else if (drive_q) begin
                        done_q  <= 1'b1;                             // only two drives
                        state_q <= S_DONE;
                    end else begin
                        // go read the following block for drive 1  R3
                        drive_q    <= 1'b1;
                        word_idx_q <= 5'h00;
                        o_dma_addr <= addr_q;
                        o_dma_req  <= 1'b1;
                        state_q    <= S_FETCH;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
            if (!split_any_q && state_q == S_IDLE) begin
                o_seek_reorder_en <= 1'b1;
            end
        end
    end
endmodule

//--- geometry_loader_consts.vh
// Purpose: constants for the drive geometry block loader
// Assumes: 16-bit parameter words, word addresses on the host bus
// Notes:   register offsets are byte addresses on a 32-bit classic Wishbone slave
`ifndef GEOMETRY_LOADER_CONSTS_VH
`define GEOMETRY_LOADER_CONSTS_VH

// block layout
`define BLK_WORDS         5'd16
`define W_UNITS           4'd0
`define W_TYPE            4'd1
`define W_HEAD_OFS        4'd2
`define W_SECTORS         4'd3
`define W_HEADS           4'd4
`define W_CYLS            4'd5
`define W_SPARE_SEC       4'd6
`define W_ALT_CYLS        4'd7
`define W_RESERVED        4'd8
`define W_SPLIT           4'd9
// limits
`define MAX_UNITS         16'h0002
`define MEDIA_FIXED       16'h0001
`define MAX_SECTORS       16'h003F
`define MAX_HEADS         16'h0010
`define MAX_CYLS          16'h0FFF
`define MAX_SPARE_SEC     16'h0001
`define MAX_ALT_CYLS      16'h007F
`define MIN_ALT_SPARED    16'h0002
// split settings
`define SPLIT_NONE        2'h0
`define SPLIT_HALF        2'h1
`define SPLIT_EIGHTH      2'h2
`define SPLIT_HEADS       2'h3
// register byte offsets
`define REG_CTRL          4'h0
`define REG_START_ADDR    4'h4
`define REG_STATUS        4'h8
`define REG_LD0_CYLS      4'hC
// control bits
`define CTRL_GO_BIT       0
// status bits
`define ST_BUSY_BIT       0
`define ST_DONE_BIT       1
`define ST_ERR_BIT        2
`define ST_REORDER_BIT    3

`endif

//--- geometry_block_check.v
// Purpose: checks one sixteen-word parameter block and derives its layout
// Assumes: words are held in flip-flops by the loader
// Notes:   purely combinational; the loader registers what it keeps
`include "geometry_loader_consts.vh"

module geometry_block_check (
    // block fields
    input  wire [15:0] i_units,
    input  wire [15:0] i_type,
    input  wire [15:0] i_head_ofs,
    input  wire [15:0] i_sectors,
    input  wire [15:0] i_heads,
    input  wire [15:0] i_cyls,
    input  wire [15:0] i_spare_sec,
    input  wire [15:0] i_alt_cyls,
    input  wire [15:0] i_reserved,
    input  wire [15:0] i_split,
    // results
    output wire        o_valid,
    output wire [5:0]  o_phys_sectors,
    output wire [12:0] o_phys_cyls,
    output wire [11:0] o_ld0_cyls,
    output wire [11:0] o_ld1_cyls,
    output wire [6:0]  o_ld0_alts,
    output wire [6:0]  o_ld1_alts,
    output wire [4:0]  o_ld0_heads,
    output wire [4:0]  o_ld1_heads,
    output wire        o_split_on
);
    wire [1:0]  split_code = i_split[1:0];   // narrow view of the split word
    wire [11:0] cyls       = i_cyls[11:0];
    wire [6:0]  alts       = i_alt_cyls[6:0];
    wire [4:0]  heads      = i_heads[4:0];

    // every field compared as an unsigned right-justified word  R4
    assign o_valid = (i_units <= `MAX_UNITS)                           // R5
                  && (i_type == `MEDIA_FIXED)                          // R6
                  && (i_sectors >= 16'h0001) && (i_sectors <= `MAX_SECTORS) // R8
                  && (i_heads >= 16'h0001) && (i_heads <= `MAX_HEADS)  // R9
                  && (i_cyls >= 16'h0001) && (i_cyls <= `MAX_CYLS)     // R10
                  && (i_spare_sec <= `MAX_SPARE_SEC)                   // R11
                  && (i_alt_cyls <= `MAX_ALT_CYLS)                     // R12
                  && ((i_spare_sec == 16'h0000)
                      || (i_alt_cyls >= `MIN_ALT_SPARED))              // R13
                  && (i_reserved == 16'h0000)                          // R15
                  && (i_split <= 16'h0003)
                  && ((split_code != `SPLIT_HEADS)
                      || (i_head_ofs >= 16'h0001 && i_head_ofs < i_heads));

    // physical totals
    assign o_phys_sectors = i_sectors[5:0] + {5'h00, i_spare_sec[0]};  // R11
    assign o_phys_cyls    = {1'b0, cyls} + {6'h00, alts};              // R12

    // per logical drive layout
    assign o_split_on  = (split_code != `SPLIT_NONE);                  // R20
    assign o_ld0_cyls  = (split_code == `SPLIT_HALF)   ? {1'b0, cyls[11:1]} :  // R16
                         (split_code == `SPLIT_EIGHTH) ? (cyls - {3'h0, cyls[11:3]}) : // R17
                         cyls;                                         // R16
    assign o_ld1_cyls  = (split_code == `SPLIT_HALF)   ? {1'b0, cyls[11:1]} :
                         (split_code == `SPLIT_EIGHTH) ? {3'h0, cyls[11:3]} :
                         (split_code == `SPLIT_HEADS)  ? cyls : 12'h000;
    // alternates shared evenly for 1 and 2, kept whole on both units for 3  R14
    assign o_ld0_alts  = (split_code == `SPLIT_HALF || split_code == `SPLIT_EIGHTH)
                         ? {1'b0, alts[6:1]} : alts;
    assign o_ld1_alts  = (split_code == `SPLIT_HALF || split_code == `SPLIT_EIGHTH)
                         ? {1'b0, alts[6:1]} :
                         (split_code == `SPLIT_HEADS) ? alts : 7'h00;
    // heads split at the offset  R18 R7
    assign o_ld0_heads = (split_code == `SPLIT_HEADS) ? i_head_ofs[4:0] : heads;
    assign o_ld1_heads = (split_code == `SPLIT_HEADS) ? (heads - i_head_ofs[4:0]) : 5'h00;
endmodule

//--- host_mem_model.sv
// Purpose: host memory model answering the loader's word reads
// Assumes: blocks sit in the lowest 256 words; the bench fills mem directly
// Notes:   released data lines toggle so a stale word never looks valid
module host_mem_model (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_reset,
    // word read port from the loader
    input  wire logic        i_req,
    input  wire logic [15:0] i_addr,
    output logic             o_ack,
    output logic [15:0]      o_data,
    // answer delay in cycles
    input  wire logic [3:0]  i_wait
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:255];  // sixteen-word blocks, contiguous upward
    logic [3:0]  cnt_q;        // cycles waited on the current request

    // answer after i_wait cycles with a one-cycle ack, then idle one cycle
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_ack  <= 1'b0;
            cnt_q  <= 4'h0;
            o_data <= 16'h5A5A;
        end else if (!o_ack && i_req && cnt_q >= i_wait) begin
            o_ack  <= 1'b1;
            o_data <= mem[i_addr[7:0]];
        end else begin
            o_ack  <= 1'b0;
            o_data <= ~o_data;
            cnt_q  <= (o_ack || !i_req) ? 4'h0 : cnt_q + 4'h1;
        end
    end
endmodule

//--- loader_checker.sv
// Purpose: port-level assertions for the geometry block loader
// Assumes: single clock, synchronous active-high reset
// Notes:   attached by bind from the bench top
module loader_checker (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_reset,
    // bus and fetch port
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        o_wb_ack,
    input  wire logic        o_dma_req,
    input  wire logic [15:0] o_dma_addr,
    input  wire logic        i_dma_ack,
    // store port
    input  wire logic        o_store_we,
    input  wire logic        o_store_drive,
    input  wire logic [1:0]  o_store_split,
    input  wire logic [4:0]  o_store_heads,
    input  wire logic [4:0]  o_store_head_ofs,
    input  wire logic [11:0] o_store_ld0_cyls,
    input  wire logic [11:0] o_store_ld1_cyls,
    input  wire logic [6:0]  o_store_ld0_alts,
    input  wire logic [6:0]  o_store_ld1_alts,
    input  wire logic [4:0]  o_store_ld0_heads,
    input  wire logic [4:0]  o_store_ld1_heads,
    input  wire logic        o_store_two_units,
    input  wire logic        o_seek_reorder_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    sequence s_taken;  i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
    sequence s_fetch;  o_dma_req && i_dma_ack; endsequence
    sequence s_drive0; o_store_we && !o_store_drive; endsequence

    property p_ack;    s_taken |=> o_wb_ack; endproperty
    property p_pulse;  o_wb_ack |=> !o_wb_ack; endproperty
    property p_hold;   o_dma_req && !i_dma_ack |=> o_dma_req && $stable(o_dma_addr); endproperty
    property p_next;   s_fetch |=> !o_dma_req || o_dma_addr == $past(o_dma_addr) + 16'h0001;
    endproperty
    property p_order;  s_drive0 ##1 o_store_we |-> o_store_drive; endproperty
    property p_two;    o_store_we && o_store_split != 2'h0 |-> o_store_two_units; endproperty
    property p_half;   o_store_we && o_store_split == 2'h1 |-> o_store_ld0_cyls == o_store_ld1_cyls;
    endproperty
    property p_eighth; o_store_we && o_store_split == 2'h2 |-> o_store_ld0_cyls >= 7 *
        o_store_ld1_cyls && o_store_ld0_cyls <= 7 * o_store_ld1_cyls + 7; endproperty
    property p_alts;   o_store_we && o_store_split[1] != o_store_split[0] |->
        o_store_ld0_alts == o_store_ld1_alts; endproperty
    property p_heads;  o_store_we && o_store_split == 2'h3 |-> o_store_ld0_heads ==
        o_store_head_ofs && o_store_ld0_heads + o_store_ld1_heads == o_store_heads; endproperty
    property p_seek;   o_store_we && o_store_two_units |=> !o_seek_reorder_en; endproperty

    a_ack:    assert property (p_ack) else $error("bus request not answered next cycle");
    a_pulse:  assert property (p_pulse) else $error("bus ack longer than one cycle");
    a_hold:   assert property (p_hold) else $error("fetch request changed before ack");
    a_next:   assert property (p_next) else $error("fetch address not contiguous");
    a_order:  assert property (p_order) else $error("second store not drive one");
    a_two:    assert property (p_two) else $error("split without two units");
    a_half:   assert property (p_half) else $error("half split unequal");
    a_eighth: assert property (p_eighth) else $error("eighth split wrong");
    a_alts:   assert property (p_alts) else $error("alternates not shared equally");
    a_heads:  assert property (p_heads) else $error("head split wrong");
    a_seek:   assert property (p_seek) else $error("reordering left on after split");
endmodule

//--- test_drive_geometry_block_loader.sv
// Purpose: bus-driven checks of the geometry block loader
// Assumes: host memory model on the fetch port, 125 MHz clock
// Notes:   each scenario resets, places blocks, starts a load and polls status
module test_drive_geometry_block_loader;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_core_clk, i_reset, cyc, stb, we, dreq, dack, swe, sdrv, two, reo;
    logic [3:0]  adr, wt;
    logic [31:0] wdat, rdat, q;
    logic        ack;
    logic [15:0] daddr, ddata;
    logic [5:0]  psec;
    logic [12:0] pcyl;
    logic [4:0]  hd, hofs, lh0, lh1;
    logic [1:0]  spl;
    logic [11:0] lc0, lc1;
    logic [6:0]  la0, la1;
    logic [12:0] ps [2], pc [2], c0 [2], c1 [2], a0 [2], a1 [2], h0 [2], h1 [2], ho [2];
    int          fails, n_checks, n_store, n_ack;
    logic [3:0]  bi [11] = '{1, 3, 3, 4, 5, 6, 7, 7, 8, 0, 9};  // word index to spoil
    logic [15:0] bv [11] = '{2, 0, 64, 17, 4096, 2, 128, 1, 1, 3, 4};

    drive_geometry_block_loader i_drive_geometry_block_loader (.i_core_clk(i_core_clk),
        .i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_dma_req(dreq),
        .o_dma_addr(daddr), .i_dma_ack(dack), .i_dma_data(ddata), .o_store_we(swe),
        .o_store_drive(sdrv), .o_store_phys_sectors(psec), .o_store_phys_cyls(pcyl),
        .o_store_heads(hd), .o_store_split(spl), .o_store_head_ofs(hofs),
        .o_store_ld0_cyls(lc0), .o_store_ld1_cyls(lc1), .o_store_ld0_alts(la0),
        .o_store_ld1_alts(la1), .o_store_ld0_heads(lh0), .o_store_ld1_heads(lh1),
        .o_store_two_units(two), .o_seek_reorder_en(reo));
    host_mem_model i_host_mem_model (.i_core_clk(i_core_clk), .i_reset(i_reset),
        .i_req(dreq), .i_addr(daddr), .o_ack(dack), .o_data(ddata), .i_wait(wt));

    // 8 ns clock
    always #4 i_core_clk = ~i_core_clk;

    // record fetches and store images by drive
    always @(posedge i_core_clk) begin
        if (!i_reset && dreq && dack) n_ack++;
        if (!i_reset && swe) begin
            n_store++;
            ps[sdrv] = psec;  pc[sdrv] = pcyl;  c0[sdrv] = lc0;  c1[sdrv] = lc1;
            a0[sdrv] = la0;  a1[sdrv] = la1;  h0[sdrv] = lh0;  h1[sdrv] = lh1;  ho[sdrv] = hofs;
        end
    end

    task give_verdict();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask

    // one classic single cycle, held until ack is sampled high
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        k = 0;
        do begin
            @(posedge i_core_clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        r = rdat;
        if (k >= 50) begin
            fails++;
            give_verdict();
        end
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge i_core_clk);
    endtask

    task rst();
        i_reset <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        i_reset <= 1'b0;
        n_store = 0;
        n_ack = 0;
    endtask

    // place a block; the word after it ends the list
    task put(input logic [7:0] b, input logic [15:0] u, t, o, s, h, c, sp, al, rv, sl);
        logic [15:0] w [16];
        w = '{u, t, o, s, h, c, sp, al, rv, sl, 0, 0, 0, 0, 0, 0};
        for (int i = 0; i < 16; i++) i_host_mem_model.mem[b + i] = w[i];
        i_host_mem_model.mem[b + 16] = 16'h0000;
    endtask

    // start a load and poll status until done or error
    task run(input logic [15:0] b, output logic [31:0] st);
        int k;
        wb(1'b1, 4'h4, {16'h0000, b}, st);
        wb(1'b1, 4'h0, 32'h0000_0001, st);
        st = 0;
        k = 0;
        while (st[2:1] === 2'b00 && k < 300) begin
            wb(1'b0, 4'h8, 32'h0, st);
            k++;
        end
        if (k >= 300) begin
            fails++;
            give_verdict();
        end
    endtask

    initial begin
        i_core_clk = 0; i_reset = 1; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; wt = 0;
        rst();
        wb(1'b0, 4'h8, 32'h0, q);  chk(q, 32'h0000_0008);
        wb(1'b0, 4'h2, 32'h0, q);  chk(q, 32'h0);
        // two drives from one block, slow memory
        wt <= 4'h3;
        put(8'h10, 2, 1, 0, 17, 4, 615, 1, 2, 0, 0);
        run(16'h0010, q);
        chk(q[3:0], 4'hA);  chk(n_store, 2);  chk(n_ack, 16);
        chk(ps[0], 18);  chk(ps[1], 18);  chk(pc[1], 617);  chk(c0[0], 615);
        // empty list
        rst();
        wt <= 4'h0;
        i_host_mem_model.mem[8'h20] = 16'h0000;
        run(16'h0020, q);
        chk(q[2:0], 3'b010);  chk(n_store, 0);  chk(n_ack, 1);
        // spoiled blocks leave the store alone
        for (int i = 0; i < 11; i++) begin
            rst();
            put(8'h30, 1, 1, 0, 17, 4, 100, 1, 2, 0, 0);
            i_host_mem_model.mem[8'h30 + bi[i]] = bv[i];
            run(16'h0030, q);
            chk(q[2], 1'b1);  chk(n_store, 0);
        end
        // head split
        rst();
        put(8'h40, 1, 1, 3, 17, 8, 300, 0, 2, 0, 3);
        run(16'h0040, q);
        chk(h0[0], 3);  chk(h1[0], 5);  chk(ho[0], 3);  chk(a1[0], 2);
        // half then eighth split over two blocks
        rst();
        put(8'h50, 1, 1, 0, 17, 4, 1001, 0, 4, 0, 1);
        put(8'h60, 1, 1, 0, 17, 4, 1003, 0, 6, 0, 2);
        run(16'h0050, q);
        chk(q[3], 1'b0);  chk(n_store, 2);  chk(n_ack, 32);
        chk(c0[0], 500);  chk(c1[0], 500);  chk(a0[0], 2);  chk(a1[0], 2);
        chk(c0[1], 878);  chk(c1[1], 125);  chk(a0[1], 3);  chk(pc[1], 1009);
        wb(1'b0, 4'hC, 32'h0, q);  chk(q, 32'd878);
        give_verdict();
    end
endmodule

bind drive_geometry_block_loader loader_checker i_loader_checker (.i_core_clk, .i_reset,
    .i_wb_cyc, .i_wb_stb, .o_wb_ack, .o_dma_req, .o_dma_addr, .i_dma_ack, .o_store_we,
    .o_store_drive, .o_store_split, .o_store_heads, .o_store_head_ofs, .o_store_ld0_cyls,
    .o_store_ld1_cyls, .o_store_ld0_alts, .o_store_ld1_alts, .o_store_ld0_heads,
    .o_store_ld1_heads, .o_store_two_units, .o_seek_reorder_en);
